// file: design/lvd_decoder.sv
// Legacy video steering and top-of-low-DRAM decode for the host side.
// Assumes requests and configuration writes are synchronous to mclk_in.
//
// Summary of operation
// - Monochrome I/O ports match on address bits 9:0 only, so aliases hit.
// - An I/O access touching any monochrome port goes to the hub link unless routing is on with no monochrome adapter.
// - Routing off and no monochrome adapter sends all legacy video to hub.
// - Routing on, no monochrome adapter: colour and mono go to graphics.
// - Routing on with monochrome adapter: colour to graphics, mono to hub.
// - Boundary field bits 7:3 give address bits 31:27, lower bits zero.
// - The boundary field resets to 01h, 128 MB in 128 MB steps.
// - Non-legacy memory addresses strictly below the boundary are claimed for DRAM.
// - Stolen base is boundary minus stolen size; SMM base is below it.
// - Graphics takes 1 to 64 MB and SMM 1, 2 or 8 MB under the boundary.
// - Mono space is memory B0000h-B7FFFh and ports 3B4,5,8,9,A,Fh.
// - With routing on and no mono, 3BC-3BFh go to graphics in its window.
`default_nettype none
module lvd_decoder
  import lvd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        cfg_wr_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  output logic      [7:0]  cfg_rdata_out,
  input  wire logic        video_route_enable_in,
  input  wire logic [15:0] graphics_io_window_base_in,
  input  wire logic [15:0] graphics_io_window_limit_in,
  input  wire logic        gfx_stolen_en_in,
  input  wire logic [6:0]  gfx_stolen_mb_in,
  input  wire logic        smm_top_segment_en_in,
  input  wire logic [1:0]  smm_top_segment_sz_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_is_io_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [3:0]  req_byte_en_in,
  output logic             resp_valid_out,
  output logic             route_dram_out,
  output logic             route_gfx_out,
  output logic             route_hub_out,
  output logic      [31:0] low_dram_top_out,
  output logic      [31:0] gfx_stolen_base_out,
  output logic      [31:0] smm_seg_base_out
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [4:0]  low_dram_boundary_field_r;
  logic        mono_adapter_present_r;
  logic [31:0] boundary;

  // Boundary field; zero writes are stored as given, software keeps off
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      low_dram_boundary_field_r <= LOW_FIELD_RST;
    end else if (cfg_wr_in && cfg_addr_in == LOW_TOP_OFS) begin
      low_dram_boundary_field_r <= cfg_wdata_in[7:LOW_FIELD_LSB];
    end
  end

  // Monochrome-present bit steering legacy mono space
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mono_adapter_present_r <= 1'b0;
    end else if (cfg_wr_in && cfg_addr_in == LEGACY_CTL_OFS) begin
      mono_adapter_present_r <= cfg_wdata_in[MONO_BIT];
    end
  end

  // Read data is registered; unmapped offsets and reserved bits read zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_rdata_out <= 8'h00;
    end else begin
      case (cfg_addr_in)
        LOW_TOP_OFS:    cfg_rdata_out <= {low_dram_boundary_field_r, 3'b000};
        LEGACY_CTL_OFS: cfg_rdata_out <= {7'h00, mono_adapter_present_r};
        default:        cfg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Field supplies bits 31:27; lower address bits taken as zero
  assign boundary = {low_dram_boundary_field_r, 27'h0};

  // ----------------------------------------------------------------
  // Stolen region bases
  // ----------------------------------------------------------------
  logic [6:0]  gfx_mb;
  logic [6:0]  smm_mb;
  logic [31:0] gfx_base;
  logic [31:0] smm_base;

  // Graphics clamped to 64 MB so a bad size cannot wrap far down
  assign gfx_mb = !gfx_stolen_en_in ? 7'h00 :
                  (gfx_stolen_mb_in > GFX_MB_MAX) ? GFX_MB_MAX :
                  gfx_stolen_mb_in;
  assign smm_mb = !smm_top_segment_en_in ? 7'h00 :
                  (smm_top_segment_sz_in == SMM_SZ_1MB) ? SMM_MB_1 :
                  (smm_top_segment_sz_in == SMM_SZ_2MB) ? SMM_MB_2 :
                  SMM_MB_8;
  assign gfx_base = boundary - ({25'h0, gfx_mb} << MB_SHIFT);
  assign smm_base = gfx_base - ({25'h0, smm_mb} << MB_SHIFT);

  // Bases registered to keep the subtract chain off the outputs
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      low_dram_top_out    <= {LOW_FIELD_RST, 27'h0};
      gfx_stolen_base_out <= {LOW_FIELD_RST, 27'h0};
      smm_seg_base_out    <= {LOW_FIELD_RST, 27'h0};
    end else begin
      low_dram_top_out    <= boundary;
      gfx_stolen_base_out <= gfx_base;
      smm_seg_base_out    <= smm_base;
    end
  end

  // ----------------------------------------------------------------
  // Per-lane I/O decode
  // ----------------------------------------------------------------
  logic [3:0] lane_mono;
  logic [3:0] lane_prn;
  logic [3:0] lane_vga;
  logic [3:0] lane_win;

  function automatic logic is_mono_port(input logic [9:0] p);
    is_mono_port = (p == MONO_IO_P0) || (p == MONO_IO_P1) ||
                   (p == MONO_IO_P2) || (p == MONO_IO_P3) ||
                   (p == MONO_IO_P4) || (p == MONO_IO_P5);
  endfunction

  // One port per enabled byte lane of the dword
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [15:0] port;
    assign port        = {req_addr_in[15:2], 2'(g)};
    // Bits 15:10 dropped so every alias counts
    assign lane_mono[g] = req_byte_en_in[g] && is_mono_port(port[9:0]);
    assign lane_prn[g]  = req_byte_en_in[g] && port[9:0] >= PRN_IO_LO &&
                          port[9:0] <= PRN_IO_HI;
    assign lane_vga[g]  = req_byte_en_in[g] && port >= VGA_IO_LO &&
                          port <= VGA_IO_HI;
    assign lane_win[g]  = port >= graphics_io_window_base_in &&
                          port <= graphics_io_window_limit_in;
  end

  // ----------------------------------------------------------------
  // Target selection
  // ----------------------------------------------------------------
  logic mono_io_any;
  logic prn_io_any;
  logic prn_in_win;
  logic mono_mem_hit;
  logic vga_mem_hit;
  logic below_top;
  logic sel_dram;
  logic sel_gfx;
  logic vga_on;
  logic mono_on;

  assign mono_io_any  = |lane_mono;
  assign prn_io_any   = |lane_prn;
  assign prn_in_win   = &(~lane_prn | lane_win);
  assign mono_mem_hit = req_addr_in >= MONO_MEM_LO &&
                        req_addr_in <= MONO_MEM_HI;
  assign vga_mem_hit  = req_addr_in >= VGA_MEM_LO &&
                        req_addr_in <= VGA_MEM_HI && !mono_mem_hit;
  assign below_top    = req_addr_in < boundary;
  assign vga_on       = video_route_enable_in;
  assign mono_on      = mono_adapter_present_r;

  // Legacy windows override DRAM; anything unclaimed falls to the hub
  always_comb begin
    sel_dram = 1'b0;
    sel_gfx  = 1'b0;
    if (req_is_io_in) begin
      if (mono_io_any || prn_io_any) begin
        // Mono touch forces hub unless graphics owns mono space
        if (!vga_on || mono_on) begin
          sel_gfx = 1'b0;
        end else begin
          sel_gfx = !prn_io_any || prn_in_win;
        end
      end else if (|lane_vga) begin
        sel_gfx = vga_on;
      end
    end else if (mono_mem_hit) begin
      sel_gfx = vga_on && !mono_on;
    end else if (vga_mem_hit) begin
      sel_gfx = vga_on;
    end else begin
      sel_dram = below_top;
    end
  end

  // One-cycle registered answer per request
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      route_dram_out <= 1'b0;
      route_gfx_out  <= 1'b0;
      route_hub_out  <= 1'b0;
    end else begin
      resp_valid_out <= req_valid_in;
      route_dram_out <= req_valid_in && sel_dram;
      route_gfx_out  <= req_valid_in && sel_gfx;
      route_hub_out  <= req_valid_in && !sel_dram && !sel_gfx;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_mono_io;
    req_valid_in && req_is_io_in && mono_io_any;
  endsequence
  sequence s_to_hub;
    resp_valid_out && route_hub_out && !route_gfx_out && !route_dram_out;
  endsequence
  sequence s_to_gfx;
    resp_valid_out && route_gfx_out && !route_hub_out && !route_dram_out;
  endsequence

  mono_alias_hub_a: assert property (
    (req_valid_in && req_is_io_in && req_byte_en_in == 4'h1 &&
     req_addr_in[9:0] == MONO_IO_P0 && mono_on) |=> s_to_hub)
    else $error("aliased mono port not sent to hub");
  mono_touch_hub_a: assert property (
    (s_mono_io and (vga_on && mono_on)) |=> s_to_hub)
    else $error("mono I/O touch not sent to hub");
  vga_off_hub_a: assert property (
    (req_valid_in && !vga_on && !mono_on &&
     (vga_mem_hit || mono_mem_hit || (req_is_io_in && |lane_vga)))
    |=> s_to_hub)
    else $error("legacy video not sent to hub with routing off");
  vga_on_gfx_a: assert property (
    (req_valid_in && !req_is_io_in && vga_on && !mono_on &&
     (vga_mem_hit || mono_mem_hit)) |=> s_to_gfx)
    else $error("legacy video memory not sent to graphics");
  mono_mem_split_a: assert property (
    (req_valid_in && !req_is_io_in && vga_on && mono_on)
    |=> (route_gfx_out == $past(vga_mem_hit)))
    else $error("colour and mono memory split wrong");
  field_reset_a: assert property (
    $fell(rst_in) |-> low_dram_boundary_field_r == 5'h01 &&
    cfg_rdata_out == 8'h00)
    else $error("boundary field not at reset value");
  dram_claim_a: assert property (
    (req_valid_in && !req_is_io_in && req_addr_in >= 32'h000C_0000)
    |=> (route_dram_out ==
         ($past(req_addr_in[31:27]) < $past(low_dram_boundary_field_r))))
    else $error("DRAM claim disagrees with boundary");
  stolen_base_a: assert property (
    ##1 (smm_seg_base_out ==
         $past(boundary) - ({25'h0, $past(gfx_mb)} << MB_SHIFT)
         - ({25'h0, $past(smm_mb)} << MB_SHIFT)))
    else $error("SMM segment base wrong");
  prn_window_a: assert property (
    (req_valid_in && req_is_io_in && vga_on && !mono_on &&
     prn_io_any && !prn_in_win) |=> s_to_hub)
    else $error("port outside graphics window not sent to hub");

endmodule // lvd_decoder
`default_nettype wire

// file: design/lvd_pkg.sv
// Constants for the legacy video and low DRAM decoder.
// Assumes a byte-wide configuration port and a 32-bit host address.
`default_nettype none
package lvd_pkg;
  // ----------------------------------------------------------------
  // Configuration offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  LOW_TOP_OFS     = 8'h9C;
  localparam logic [7:0]  LEGACY_CTL_OFS  = 8'h97;
  localparam logic [4:0]  LOW_FIELD_RST   = 5'h01;
  localparam int          LOW_FIELD_LSB   = 3;
  localparam int          LOW_ADDR_LSB    = 27;
  localparam int          MONO_BIT        = 0;
  localparam int          MB_SHIFT        = 20;
  // ----------------------------------------------------------------
  // Legacy memory windows
  // ----------------------------------------------------------------
  localparam logic [31:0] VGA_MEM_LO      = 32'h000A_0000;
  localparam logic [31:0] MONO_MEM_LO     = 32'h000B_0000;
  localparam logic [31:0] MONO_MEM_HI     = 32'h000B_7FFF;
  localparam logic [31:0] VGA_MEM_HI      = 32'h000B_FFFF;
  // ----------------------------------------------------------------
  // Legacy I/O ports (10-bit form for aliased mono and printer decode, 16-bit VGA)
  // ----------------------------------------------------------------
  localparam logic [9:0]  MONO_IO_P0      = 10'h3B4;
  localparam logic [9:0]  MONO_IO_P1      = 10'h3B5;
  localparam logic [9:0]  MONO_IO_P2      = 10'h3B8;
  localparam logic [9:0]  MONO_IO_P3      = 10'h3B9;
  localparam logic [9:0]  MONO_IO_P4      = 10'h3BA;
  localparam logic [9:0]  MONO_IO_P5      = 10'h3BF;
  localparam logic [9:0]  PRN_IO_LO       = 10'h3BC;
  localparam logic [9:0]  PRN_IO_HI       = 10'h3BF;
  localparam logic [15:0] VGA_IO_LO       = 16'h03C0;
  localparam logic [15:0] VGA_IO_HI       = 16'h03DF;
  // ----------------------------------------------------------------
  // SMM segment size codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  SMM_SZ_1MB      = 2'h0;
  localparam logic [1:0]  SMM_SZ_2MB      = 2'h1;
  localparam logic [6:0]  SMM_MB_1        = 7'h01;
  localparam logic [6:0]  SMM_MB_2        = 7'h02;
  localparam logic [6:0]  SMM_MB_8        = 7'h08;
  localparam logic [6:0]  GFX_MB_MAX      = 7'h40;
endpackage : lvd_pkg
`default_nettype wire

// file: tb/lvd_decoder_tb_top.sv
// Self-checking bench for the legacy video and low DRAM decoder.
// Assumes lvd_host_model drives the request and config ports.
`default_nettype none
module lvd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cfg_wr, req_valid, req_is_io, resp_valid;
  logic        r_dram, r_gfx, r_hub;
  logic        vga = 1'b0;
  logic        gfx_en = 1'b0;
  logic        smm_en = 1'b0;
  logic [6:0]  gfx_mb = 7'h00;
  logic [1:0]  smm_sz = 2'h0;
  logic [15:0] win_lo = 16'h03B0;
  logic [15:0] win_hi = 16'h03BF;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
  logic [31:0] req_addr, top, gfx_base, smm_base;
  logic [3:0]  req_be;
  logic [34:0] expq[$];
  logic [34:0] e;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 43343;
  int          cyc = 0;
  int          i, k, m;
  // Legacy cases; route code per mode in 2-bit slots: 1 gfx, 2 hub
  localparam logic [31:0] TAD[10] = '{32'h000B_0000, 32'h000B_7FFF,
    32'h000B_8000, 32'h000A_0000, 32'h0000_7BB4, 32'h0000_FFB4,
    32'h0000_03B4, 32'h0000_03BC, 32'h0000_03C0, 32'h0000_03B4};
  localparam logic [9:0] TIO = 10'h3F0;
  localparam logic [3:0] TBE[10] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h1,
    4'h2, 4'hF, 4'h1, 4'h1, 4'h4};
  localparam logic [5:0] TEX[10] = '{6'h26, 6'h26, 6'h16, 6'h16,
    6'h26, 6'h26, 6'h26, 6'h26, 6'h16, 6'h2A};
  // ----------------------------------------------------------
  // Clock, host model and design
  // ----------------------------------------------------------
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc <= cyc + 1;
  lvd_host_model hm (.mclk_in(mclk_in), .req_valid_out(req_valid),
    .req_is_io_out(req_is_io), .req_addr_out(req_addr),
    .req_byte_en_out(req_be), .cfg_wr_out(cfg_wr),
    .cfg_addr_out(cfg_addr), .cfg_wdata_out(cfg_wdata));
  lvd_decoder dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr),
    .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata),
    .video_route_enable_in(vga), .graphics_io_window_base_in(win_lo),
    .graphics_io_window_limit_in(win_hi), .gfx_stolen_en_in(gfx_en),
    .gfx_stolen_mb_in(gfx_mb), .smm_top_segment_en_in(smm_en),
    .smm_top_segment_sz_in(smm_sz), .req_valid_in(req_valid),
    .req_is_io_in(req_is_io), .req_addr_in(req_addr),
    .req_byte_en_in(req_be), .resp_valid_out(resp_valid),
    .route_dram_out(r_dram), .route_gfx_out(r_gfx),
    .route_hub_out(r_hub), .low_dram_top_out(top),
    .gfx_stolen_base_out(gfx_base), .smm_seg_base_out(smm_base));
  // ----------------------------------------------------------
  // Tasks and response monitor
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Route one-hot {dram,gfx,hub} against the note taken at issue
  task automatic chk_route(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: route %b expected %b", $time,
               got, exp);
    end
  endtask
  // Config read byte against the documented register image
  task automatic chk_cfg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: config read %h expected %h", $time,
               got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Note expected one-hot {dram,gfx,hub} and the answer cycle
  task automatic req(input logic io, input logic [31:0] a,
                     input logic [3:0] be, input logic [1:0] c);
    hm.issue(io, a, be);
    expq.push_back({32'(cyc + 1),
      (c == 2'h0) ? 3'h4 : (c == 2'h1) ? 3'h2 : 3'h1});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    hm.cfg_sel(a);
    tick(1);
    chk_cfg(cfg_rdata, exp);
  endtask
  task automatic drain();
    hm.idle();
    tick(2);
    chk(expq.size(), 0, "missing response");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Mid-cycle sampling avoids racing the registered outputs
  always @(negedge mclk_in) begin
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) chk(0, 1, "unexpected response");
      else begin
        e = expq.pop_front();
        chk_route({r_dram, r_gfx, r_hub}, e[2:0]);
        chk(cyc, e[34:3], "response latency");
      end
    end
  end
  // Watchdog; the full run needs well under a thousand cycles
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    tick(5);
    rst_in = 1'b0;
    tick(1);
    rd(8'h9C, 8'h08);
    rd(8'h97, 8'h00);
    rd(8'h50, 8'h00);
    chk(top, 32'h0800_0000, "reset boundary");
    chk(smm_base, 32'h0800_0000, "disabled bases");
    $display("test reset values done");
    hm.cfg_wr(8'h9C, 8'hB8);
    rd(8'h9C, 8'hB8);
    chk(top, 32'hB800_0000, "boundary");
    req(1'b0, 32'hB7FF_FFFF, 4'hF, 2'h0);
    req(1'b0, 32'hB800_0000, 4'hF, 2'h2);
    for (i = 0; i < 8; i++) req(1'b0,
      ($random(seed) & 32'h7FFF_FFFF) | 32'h0010_0000, 4'hF, 2'h0);
    drain();
    $display("test dram decode done");
    gfx_en = 1'b1;
    gfx_mb = 7'h20;
    smm_en = 1'b1;
    for (k = 0; k < 4; k++) begin
      smm_sz = k[1:0];
      tick(2);
      chk(gfx_base, 32'hB600_0000, "stolen base");
      chk(smm_base, 32'hB600_0000 - ((k == 0) ? 32'h0010_0000 :
        (k == 1) ? 32'h0020_0000 : 32'h0080_0000), "smm base");
    end
    gfx_mb = 7'h64;
    tick(2);
    chk(gfx_base, 32'hB400_0000, "stolen clamp");
    $display("test carve bases done");
    for (m = 0; m < 3; m++) begin
      vga = (m != 0);
      hm.cfg_wr(8'h97, {7'h00, m == 2});
      for (i = 0; i < 10; i++) req(TIO[i], TAD[i], TBE[i],
        TEX[i][2*m +: 2]);
      drain();
    end
    hm.cfg_wr(8'h97, 8'h00);
    win_lo = 16'h03C0;
    win_hi = 16'h03DF;
    req(1'b1, 32'h0000_03BC, 4'h1, 2'h2);
    req(1'b1, 32'h0000_03C0, 4'h1, 2'h1);
    drain();
    $display("test legacy routing done");
    end_of_test();
  end
endmodule // lvd_decoder_tb_top
`default_nettype wire

// file: tb/lvd_host_model.sv
// Host bus model: issues decode requests and config cycles.
// Assumes calls start just after a rising edge of mclk_in.
`default_nettype none
module lvd_host_model (
  input  wire logic        mclk_in,
  output logic             req_valid_out,
  output logic             req_is_io_out,
  output logic      [31:0] req_addr_out,
  output logic      [3:0]  req_byte_en_out,
  output logic             cfg_wr_out,
  output logic      [7:0]  cfg_addr_out,
  output logic      [7:0]  cfg_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------
  // Idle bus at time zero
  initial begin
    req_valid_out = 1'b0;
    req_is_io_out = 1'b0;
    req_addr_out = 32'h0000_0000;
    req_byte_en_out = 4'h0;
    cfg_wr_out = 1'b0;
    cfg_addr_out = 8'h00;
    cfg_wdata_out = 8'h00;
  end
  // Strobe stays up so requests run back to back
  task automatic issue(input logic io, input logic [31:0] a,
                       input logic [3:0] be);
    @(posedge mclk_in);
    #1;
    req_valid_out = 1'b1;
    req_is_io_out = io;
    req_addr_out = a;
    req_byte_en_out = be;
  endtask
  // Released address flips so stale values cannot match
  task automatic idle();
    @(posedge mclk_in);
    #1;
    req_valid_out = 1'b0;
    req_addr_out = ~req_addr_out;
    req_byte_en_out = ~req_byte_en_out;
  endtask
  // One-cycle write pulse
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1;
    cfg_wr_out = 1'b1;
    cfg_addr_out = a;
    cfg_wdata_out = d;
    @(posedge mclk_in);
    #1;
    cfg_wr_out = 1'b0;
    cfg_wdata_out = ~d;
  endtask
  task automatic cfg_sel(input logic [7:0] a);
    @(posedge mclk_in);
    #1;
    cfg_addr_out = a;
  endtask
endmodule // lvd_host_model
`default_nettype wire
